// ### watchdog_countdown.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module watchdog_countdown #(
  parameter int PRESCALE = wdg_pkg::PRESCALE_DIV
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic [wdg_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [wdg_pkg::CTX_W-1:0]   bus_ctx,
  input  wire logic                        cfg_lock,
  input  wire logic                        minor_rst,
  input  wire logic                        dbg_freeze,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             irq,
  output logic                             nmi_warn,
  output logic [2:0]                       nmi_level,
  output logic                             ctx_switch_req,
  output logic                             sys_reset_req
);
  localparam int HI_W = wdg_pkg::COUNT_W - wdg_pkg::RELOAD_LO_W;

  function automatic logic hit(input logic [wdg_pkg::ADDR_W-1:0] a,
                               input logic [7:0]                 ofs);
    hit = (a == ofs);
  endfunction

  logic [31:0]                prdata_q;
  logic                       pready_q;
  logic                       pslverr_q;
  logic                       irq_q;
  logic                       nmi_q;
  logic [2:0]                 nmi_level_q;
  logic                       ctx_sw_q;
  logic                       sysrst_q;
  logic                       en_q;
  logic                       int_en_q;
  logic [HI_W-1:0]            reload_hi_q;
  logic [wdg_pkg::EVT_W-1:0]  status_q;
  logic [wdg_pkg::EVT_W-1:0]  mask_q;
  logic                       load_q;
  logic                       frz_meta_q;
  logic                       frz_q;

  logic                       setup_rd;
  logic                       acc;
  logic                       wr_ctrl;
  logic                       wr_reload;
  logic                       wr_mask;
  logic                       rd_status;
  logic                       may_write;
  logic                       en_set;
  logic                       mapped;
  logic [wdg_pkg::EVT_W-1:0]  events;
  logic [wdg_pkg::EVT_W-1:0]  status_d;
  logic [31:0]                rd_word;

  guard_if g ();

  guard_counter #(
    .PRESCALE (PRESCALE)
  ) u_counter (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .g    (g)
  );

  assign g.load  = load_q;
  assign g.run   = en_q && !frz_q;
  assign g.start = {reload_hi_q, wdg_pkg::RELOAD_FIXED}; // [R2]

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign irq            = irq_q;
  assign nmi_warn       = nmi_q;
  assign nmi_level      = nmi_level_q;
  assign ctx_switch_req = ctx_sw_q;
  assign sys_reset_req  = sysrst_q;

  //////////////////////////////////////////////////////////////////////////
  // apb decode: one wait state, so access completes on second penable
  assign acc       = psel && penable && pready_q;
  assign setup_rd  = psel && penable && !pready_q;
  assign may_write = (bus_ctx == wdg_pkg::MASTER_CTX) && !cfg_lock;
  assign wr_ctrl   = acc && pwrite && hit(paddr, wdg_pkg::OFS_CTRL);
  assign wr_reload = acc && pwrite && hit(paddr, wdg_pkg::OFS_RELOAD);
  assign wr_mask   = acc && pwrite && hit(paddr, wdg_pkg::OFS_MASK);
  assign rd_status = acc && !pwrite && hit(paddr, wdg_pkg::OFS_STATUS);
  assign en_set    = wr_ctrl && may_write && pwdata[wdg_pkg::CTRL_EN_BIT]
                     && !en_q;
  assign mapped    = hit(paddr, wdg_pkg::OFS_CTRL)   ||
                     hit(paddr, wdg_pkg::OFS_RELOAD) ||
                     hit(paddr, wdg_pkg::OFS_STATUS) ||
                     hit(paddr, wdg_pkg::OFS_MASK)   ||
                     hit(paddr, wdg_pkg::OFS_COUNT);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(paddr, wdg_pkg::OFS_CTRL)) begin
      rd_word[wdg_pkg::CTRL_EN_BIT] = en_q;
      rd_word[wdg_pkg::CTRL_IE_BIT] = int_en_q;
    end else if (hit(paddr, wdg_pkg::OFS_RELOAD)) begin
      rd_word[wdg_pkg::COUNT_W-1:0] = g.start;
    end else if (hit(paddr, wdg_pkg::OFS_STATUS)) begin
      rd_word[wdg_pkg::EVT_W-1:0] = status_q;
    end else if (hit(paddr, wdg_pkg::OFS_MASK)) begin
      rd_word[wdg_pkg::EVT_W-1:0] = mask_q;
    end else if (hit(paddr, wdg_pkg::OFS_COUNT)) begin
      rd_word[wdg_pkg::COUNT_W-1:0] = g.count;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= setup_rd;
      if (setup_rd) begin
        // reads are open to every context [R11] [R12]
        pslverr_q <= !mapped;
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_q     <= wdg_pkg::CTRL_RESET[wdg_pkg::CTRL_EN_BIT]; // [R16]
      int_en_q <= wdg_pkg::CTRL_RESET[wdg_pkg::CTRL_IE_BIT]; // [R16]
    end else if (ce) begin
      if (wr_ctrl && may_write) begin // [R10] [R11]
        // enable can only be set; clearing needs power-on reset
        en_q     <= en_q | pwdata[wdg_pkg::CTRL_EN_BIT]; // [R8]
        int_en_q <= pwdata[wdg_pkg::CTRL_IE_BIT]; // [R7]
      end
    end
  end

  // start value; locked while running so a pass length cannot change
  always_ff @(posedge mclk) begin
    if (rst) begin
      reload_hi_q <= wdg_pkg::RELOAD_RESET[wdg_pkg::COUNT_W-1:
                                           wdg_pkg::RELOAD_LO_W]; // [R2]
    end else if (ce) begin
      if (wr_reload && may_write && !en_q) begin // [R12] [R13]
        reload_hi_q <= pwdata[wdg_pkg::COUNT_W-1:wdg_pkg::RELOAD_LO_W];
      end
    end
  end

  // restart pulse; minor reset leaves enable alone
  always_ff @(posedge mclk) begin
    if (rst) begin
      load_q <= 1'b0;
    end else if (ce) begin
      load_q <= wr_ctrl || en_set || minor_rst; // [R3] [R9] [R14]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // freeze comes from the debug port domain
  always_ff @(posedge mclk) begin
    if (rst) begin
      frz_meta_q <= 1'b0;
      frz_q      <= 1'b0;
    end else if (ce) begin
      frz_meta_q <= dbg_freeze;
      frz_q      <= frz_meta_q; // [R15]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // warning nmi and system reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      nmi_q       <= 1'b0;
      ctx_sw_q    <= 1'b0;
      sysrst_q    <= 1'b0;
      nmi_level_q <= 3'h0;
    end else if (ce) begin
      nmi_q       <= g.warn_hit && int_en_q; // [R4] [R7]
      ctx_sw_q    <= g.warn_hit && int_en_q; // [R6]
      sysrst_q    <= g.zero_hit; // [R5]
      nmi_level_q <= wdg_pkg::NMI_LEVEL; // [R6]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky status, cleared by read; a new event beats the clear
  assign events[wdg_pkg::ST_WARN_BIT]   = g.warn_hit && int_en_q;
  assign events[wdg_pkg::ST_EXPIRE_BIT] = g.zero_hit;
  assign status_d = (status_q & {wdg_pkg::EVT_W{~rd_status}}) | events;

  always_ff @(posedge mclk) begin
    if (rst) begin
      status_q <= '0;
      mask_q   <= '0;
      irq_q    <= 1'b0;
    end else if (ce) begin
      status_q <= status_d;
      if (wr_mask && may_write) begin
        mask_q <= pwdata[wdg_pkg::EVT_W-1:0];
      end
      irq_q <= |(status_d & mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  property p_en_sticky;
    @(posedge mclk) disable iff (rst)
      en_q |=> en_q;
  endproperty
  a_en_sticky: assert property (p_en_sticky) // [R8]
    else $error("timer enable dropped without power-on reset");

  property p_ctrl_reload;
    @(posedge mclk) disable iff (rst)
      (ce && wr_ctrl) |=> load_q ##1 g.count == $past(g.start);
  endproperty
  a_ctrl_reload: assert property (p_ctrl_reload) // [R9]
    else $error("control write did not reload the counter");

  property p_foreign_ctrl;
    @(posedge mclk) disable iff (rst)
      (ce && wr_ctrl && bus_ctx != wdg_pkg::MASTER_CTX)
      |=> $stable(int_en_q) && $stable(en_q);
  endproperty
  a_foreign_ctrl: assert property (p_foreign_ctrl) // [R10]
    else $error("non-master write changed control data");

  property p_locked_ctrl;
    @(posedge mclk) disable iff (rst)
      (ce && wr_ctrl && cfg_lock) |=> $stable(int_en_q);
  endproperty
  a_locked_ctrl: assert property (p_locked_ctrl) // [R11]
    else $error("control changed while locked");

  property p_reload_guard;
    @(posedge mclk) disable iff (rst)
      (ce && wr_reload && (en_q || !may_write)) |=> $stable(reload_hi_q);
  endproperty
  a_reload_guard: assert property (p_reload_guard) // [R12]
    else $error("start value changed while protected");

  property p_reload_running;
    @(posedge mclk) disable iff (rst)
      en_q |=> $stable(reload_hi_q);
  endproperty
  a_reload_running: assert property (p_reload_running) // [R13]
    else $error("start value changed while timer enabled");

  property p_nibble;
    @(posedge mclk) disable iff (rst)
      (ce && setup_rd && !pwrite && hit(paddr, wdg_pkg::OFS_RELOAD))
      |=> prdata_q[3:0] == wdg_pkg::RELOAD_FIXED;
  endproperty
  a_nibble: assert property (p_nibble) // [R2]
    else $error("start value low nibble not all ones");

  property p_warn_path;
    @(posedge mclk) disable iff (rst)
      (ce && g.warn_hit) |=> nmi_q == $past(int_en_q) &&
                             ctx_sw_q == $past(int_en_q);
  endproperty
  a_warn_path: assert property (p_warn_path) // [R4]
    else $error("warning nmi does not follow enable");

  property p_nmi_level;
    @(posedge mclk) disable iff (rst)
      nmi_q |-> ctx_sw_q && nmi_level_q == wdg_pkg::NMI_LEVEL;
  endproperty
  a_nmi_level: assert property (p_nmi_level) // [R6]
    else $error("nmi without level 7 or context switch");

  property p_expire;
    @(posedge mclk) disable iff (rst)
      (ce && g.zero_hit) |=> sysrst_q;
  endproperty
  a_expire: assert property (p_expire) // [R5]
    else $error("zero count gave no system reset");

  property p_minor;
    @(posedge mclk) disable iff (rst)
      (ce && minor_rst) |=> load_q && en_q == $past(en_q);
  endproperty
  a_minor: assert property (p_minor) // [R14]
    else $error("minor reset mishandled");

  property p_first_enable;
    @(posedge mclk) disable iff (rst)
      (ce && $rose(en_q)) |=> g.count == g.start;
  endproperty
  a_first_enable: assert property (p_first_enable) // [R3]
    else $error("first enable did not load the start value");

  property p_foreign_reload;
    @(posedge mclk) disable iff (rst)
      (ce && wr_ctrl && !may_write) |=> load_q;
  endproperty
  a_foreign_reload: assert property (p_foreign_reload) // [R10]
    else $error("refused control write did not reload");

  property p_nmi_gated;
    @(posedge mclk) disable iff (rst)
      (ce && !int_en_q) |=> !nmi_q && !ctx_sw_q;
  endproperty
  a_nmi_gated: assert property (p_nmi_gated) // [R7]
    else $error("warning nmi raised with warning disabled");

  property p_warn_status;
    @(posedge mclk) disable iff (rst)
      (ce && g.warn_hit && !int_en_q && !rd_status)
      |=> $stable(status_q[wdg_pkg::ST_WARN_BIT]);
  endproperty
  a_warn_status: assert property (p_warn_status) // [R7]
    else $error("disabled warning set its status bit");

  // two frozen cycles cover the pipeline from counter to outputs
  property p_freeze_quiet;
    @(posedge mclk) disable iff (rst)
      (ce && $past(ce) && frz_q && $past(frz_q))
      |=> !nmi_q && !sysrst_q;
  endproperty
  a_freeze_quiet: assert property (p_freeze_quiet) // [R15]
    else $error("warning or reset while frozen");

  c_nmi:     cover property (@(posedge mclk) disable iff (rst) nmi_q);
  c_sysrst:  cover property (@(posedge mclk) disable iff (rst) sysrst_q);
  c_foreign: cover property (@(posedge mclk) disable iff (rst)
                             wr_ctrl && bus_ctx != wdg_pkg::MASTER_CTX);
  c_frozen:  cover property (@(posedge mclk) disable iff (rst)
                             en_q && frz_q);
  c_minor:   cover property (@(posedge mclk) disable iff (rst)
                             minor_rst && en_q);
endmodule
`default_nettype wire

// ### wdg_pkg.sv
// Summary of operation
// R1 - guard counter is 16 bits, decremented once per 2048 clock cycles
// R2 - only upper 12 start-value bits writable, low nibble ones, resets to 0x000F
// R3 - counter loads start value on first enable and on each restart
// R4 - warning raised when count reaches 0x000F if warning enable is set
// R5 - without restart, count continues and system reset fires at zero
// R6 - warning is non-maskable, level 7, and forces switch to master context
// R7 - control bit 2 enables the warning interrupt
// R8 - control bit 1 enables timer; sticky until power-on reset
// R9 - any control write, from any context, reloads the counter
// R10 - control write from non-master context keeps data unchanged, only reloads
// R11 - control data written only by master while lock clear; reads from all
// R12 - start value written only by master while lock clear; reads from all
// R13 - start value writes ignored while timer enable is set
// R14 - minor reset reloads counter and keeps timer enabled
// R15 - debug freeze stops decrementing, so no warning or reset
// R16 - control register reads zero after reset
// R17 - software writes start value before setting enable
// R18 - software writes control register periodically before expiry
// R19 - warning raised once per countdown pass, rearmed only by a reload
package wdg_pkg;
  localparam int          COUNT_W       = 16;
  localparam int          PRESCALE_DIV  = 2048;
  localparam int          ADDR_W        = 8;
  localparam int          CTX_W         = 3;

  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_RELOAD    = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_MASK      = 8'h0C;
  localparam logic [7:0]  OFS_COUNT     = 8'h10;

  localparam int          CTRL_EN_BIT   = 1;
  localparam int          CTRL_IE_BIT   = 2;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [15:0] RELOAD_RESET  = 16'h000F;
  localparam logic [3:0]  RELOAD_FIXED  = 4'hF;
  localparam int          RELOAD_LO_W   = 4;
  localparam logic [15:0] WARN_VALUE    = 16'h000F;
  localparam logic [15:0] ZERO_VALUE    = 16'h0000;

  localparam int          ST_WARN_BIT   = 0;
  localparam int          ST_EXPIRE_BIT = 1;
  localparam int          EVT_W         = 2;

  localparam logic [2:0]  MASTER_CTX    = 3'h0;
  localparam logic [2:0]  NMI_LEVEL     = 3'h7;

  typedef enum logic [2:0] {
    CNT_IDLE = 3'b001,
    CNT_RUN  = 3'b010,
    CNT_DONE = 3'b100
  } cnt_state_t;
endpackage

// ### guard_if.sv
`timescale 1ns/1ps
`default_nettype none
interface guard_if;
  logic                         load;
  logic                         run;
  logic [wdg_pkg::COUNT_W-1:0]  start;
  logic [wdg_pkg::COUNT_W-1:0]  count;
  logic                         warn_hit;
  logic                         zero_hit;
  modport ctl (output load, run, start, input count, warn_hit, zero_hit);
  modport cnt (input load, run, start, output count, warn_hit, zero_hit);
endinterface
`default_nettype wire

// ### guard_counter.sv
`timescale 1ns/1ps
`default_nettype none
module guard_counter #(
  parameter int PRESCALE = wdg_pkg::PRESCALE_DIV
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  guard_if.cnt      g
);
  localparam int PW = $clog2(PRESCALE);

  logic [PW-1:0]               pre_q;
  logic [wdg_pkg::COUNT_W-1:0] count_q;
  wdg_pkg::cnt_state_t         state_q;
  logic                        warned_q;
  logic                        warn_q;
  logic                        zero_q;
  logic                        tick;

  assign tick       = (pre_q == PW'(PRESCALE - 1)) && g.run;
  assign g.count    = count_q;
  assign g.warn_hit = warn_q;
  assign g.zero_hit = zero_q;

  //////////////////////////////////////////////////////////////////////////
  // prescaler restarts on every load so a pass is never short
  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_q <= '0;
    end else if (ce) begin
      if (g.load || !g.run) begin
        pre_q <= pre_q & {PW{~g.load}};
      end else if (tick) begin // [R1]
        pre_q <= '0;
      end else begin
        pre_q <= pre_q + PW'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= wdg_pkg::CNT_IDLE;
      count_q <= wdg_pkg::RELOAD_RESET;
      zero_q  <= 1'b0;
    end else if (ce) begin
      zero_q <= 1'b0;
      if (g.load) begin // [R3] [R14]
        state_q <= wdg_pkg::CNT_RUN;
        count_q <= g.start;
      end else begin
        case (state_q)
          wdg_pkg::CNT_IDLE: begin
            state_q <= wdg_pkg::CNT_IDLE;
          end
          wdg_pkg::CNT_RUN: begin
            // run drops while frozen, so tick never fires [R15]
            if (tick) begin // [R1]
              count_q <= count_q - wdg_pkg::COUNT_W'(1);
              if (count_q == wdg_pkg::COUNT_W'(1)) begin // [R5]
                zero_q  <= 1'b1;
                state_q <= wdg_pkg::CNT_DONE;
              end
            end
          end
          wdg_pkg::CNT_DONE: begin
            // hold at zero until reloaded; chip reset normally follows
            state_q <= wdg_pkg::CNT_DONE;
          end
          default: begin
            state_q <= wdg_pkg::CNT_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // warning point is caught by level, also when loaded straight onto it
  always_ff @(posedge mclk) begin
    if (rst) begin
      warned_q <= 1'b0;
      warn_q   <= 1'b0;
    end else if (ce) begin
      warn_q <= 1'b0;
      if (g.load) begin // [R19]
        warned_q <= 1'b0;
      end else if (state_q == wdg_pkg::CNT_RUN && g.run && !warned_q &&
                   count_q == wdg_pkg::WARN_VALUE) begin // [R4] [R19]
        warned_q <= 1'b1;
        warn_q   <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  property p_tick_spacing;
    @(posedge mclk) disable iff (rst)
      (ce && state_q == wdg_pkg::CNT_RUN && !g.load && count_q != '0 &&
       $past(count_q) != count_q && $past(ce) && !$past(g.load))
      |-> $past(pre_q) == PW'(PRESCALE - 1);
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) // [R1]
    else $error("count moved without a full prescale period");

  property p_load_value;
    @(posedge mclk) disable iff (rst)
      (ce && g.load) |=> count_q == $past(g.start);
  endproperty
  a_load_value: assert property (p_load_value) // [R3]
    else $error("counter did not take the start value");

  property p_freeze_hold;
    @(posedge mclk) disable iff (rst)
      (ce && !g.run && !g.load) |=> count_q == $past(count_q) && !zero_q;
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) // [R15]
    else $error("counter moved while stopped");

  property p_warn_once;
    @(posedge mclk) disable iff (rst)
      warn_q |-> !$past(warned_q) && warned_q;
  endproperty
  a_warn_once: assert property (p_warn_once) // [R19]
    else $error("warning repeated within one pass");
endmodule
`default_nettype wire

// ### watchdog_countdown_tb.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_countdown_tb;
  localparam int         PS    = 4;
  localparam logic [7:0] A_BAD = 8'h14;

  logic        mclk;
  logic        rst;
  logic        ce;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [2:0]  bus_ctx;
  logic        cfg_lock;
  logic        minor_rst;
  logic        dbg_freeze;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        nmi_warn;
  logic [2:0]  nmi_level;
  logic        ctx_switch_req;
  logic        sys_reset_req;
  int          errors;
  int          compares;
  int          cyc;
  int          nmi_cnt;
  int          exp_cnt;
  logic [31:0] v;
  logic [15:0] cnt0;
  logic        e;

  watchdog_countdown #(.PRESCALE(PS)) i_dut (
    .mclk(mclk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .bus_ctx(bus_ctx), .cfg_lock(cfg_lock), .minor_rst(minor_rst),
    .dbg_freeze(dbg_freeze), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .nmi_warn(nmi_warn),
    .nmi_level(nmi_level), .ctx_switch_req(ctx_switch_req),
    .sys_reset_req(sys_reset_req)
  );

  always #20 mclk = ~mclk;

  //////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic [2:0] ctx,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    bus_ctx <= ctx;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 50), 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [2:0] ctx);
    apb(a, 1'b1, d, ctx, v, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0, 3'h0, v, e);
    chk(v, exp);
  endtask

  task automatic rd_count;
    apb(wdg_pkg::OFS_COUNT, 1'b0, 32'h0, 3'h0, v, e);
  endtask

  // sel 0 waits for the warning pulse, sel 1 for the reset pulse
  task automatic wait_on(input logic sel, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((sel ? sys_reset_req : nmi_warn) !== 1'b1 && n < lim);
    chk(32'(n < lim), 32'h1);
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cyc++;
    if (nmi_warn === 1'b1) begin
      nmi_cnt++;
    end
    if (nmi_warn === 1'b1 || ctx_switch_req === 1'b1) begin
      chk({31'h0, ctx_switch_req}, {31'h0, nmi_warn});
    end
    if (cyc > 20000) begin
      errors++;
      test_done();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    bus_ctx = 3'h0;
    cfg_lock = 1'b0;
    minor_rst = 1'b0;
    dbg_freeze = 1'b0;
    errors = 0;
    compares = 0;
    cyc = 0;
    nmi_cnt = 0;
    do_reset();
    rdc(wdg_pkg::OFS_CTRL, 32'h0000_0000);
    rdc(wdg_pkg::OFS_RELOAD, 32'h0000_000F);
    chk({29'h0, nmi_level}, 32'h0000_0007);
    apb(A_BAD, 1'b0, 32'h0, 3'h0, v, e);
    chk({31'h0, e}, 32'h0000_0001);
    wr(wdg_pkg::OFS_RELOAD, 32'hFFFF_1234, 3'h0);
    rdc(wdg_pkg::OFS_RELOAD, 32'h0000_123F);
    wr(wdg_pkg::OFS_RELOAD, 32'h0000_0030, 3'h1);
    rdc(wdg_pkg::OFS_RELOAD, 32'h0000_123F);
    // locked master writes are refused silently
    cfg_lock <= 1'b1;
    wr(wdg_pkg::OFS_RELOAD, 32'h0000_0030, 3'h0);
    wr(wdg_pkg::OFS_CTRL, 32'h0000_0006, 3'h0);
    cfg_lock <= 1'b0;
    rdc(wdg_pkg::OFS_RELOAD, 32'h0000_123F);
    rdc(wdg_pkg::OFS_CTRL, 32'h0000_0000);
    wr(wdg_pkg::OFS_CTRL, 32'h0000_0006, 3'h3);
    rdc(wdg_pkg::OFS_CTRL, 32'h0000_0000);
    wr(wdg_pkg::OFS_RELOAD, 32'h0000_0030, 3'h0);
    rdc(wdg_pkg::OFS_RELOAD, 32'h0000_003F);
    wr(wdg_pkg::OFS_MASK, 32'h0000_0003, 3'h0);
    wr(wdg_pkg::OFS_CTRL, 32'h0000_0006, 3'h0);
    rdc(wdg_pkg::OFS_CTRL, 32'h0000_0006);
    wr(wdg_pkg::OFS_RELOAD, 32'h0000_0FF0, 3'h0);
    rdc(wdg_pkg::OFS_RELOAD, 32'h0000_003F);
    // 44 cycles between samples: eleven whole prescale periods
    rd_count();
    cnt0 = v[15:0];
    repeat (40) @(posedge mclk);
    rd_count();
    chk({16'h0, cnt0 - v[15:0]}, 32'h0000_000B);
    wr(wdg_pkg::OFS_CTRL, 32'h0000_0000, 3'h2);
    rd_count();
    chk(32'(v[15:0] >= 16'h003D), 32'h1);
    rdc(wdg_pkg::OFS_CTRL, 32'h0000_0006);
    repeat (40) @(posedge mclk);
    minor_rst <= 1'b1;
    @(posedge mclk);
    minor_rst <= 1'b0;
    rd_count();
    chk(32'(v[15:0] >= 16'h003D), 32'h1);
    rdc(wdg_pkg::OFS_CTRL, 32'h0000_0006);
    // clock enable low holds everything; only 4 live cycles remain
    rd_count();
    cnt0 = v[15:0];
    ce <= 1'b0;
    repeat (40) @(posedge mclk);
    ce <= 1'b1;
    rd_count();
    chk(32'((cnt0 - v[15:0]) <= 16'h0001), 32'h1);
    // freeze passes a two-flop synchroniser first
    dbg_freeze <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_count();
    cnt0 = v[15:0];
    repeat (40) @(posedge mclk);
    rd_count();
    chk({16'h0, v[15:0]}, {16'h0, cnt0});
    dbg_freeze <= 1'b0;
    exp_cnt = nmi_cnt;
    wait_on(1'b0, 400);
    rd_count();
    chk(32'(v[15:0] inside {16'h000F, 16'h000E}), 32'h1);
    chk({29'h0, nmi_level}, 32'h0000_0007);
    chk({31'h0, irq}, 32'h0000_0001);
    rdc(wdg_pkg::OFS_STATUS, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0000_0000);
    wait_on(1'b1, 200);
    chk(32'(nmi_cnt - exp_cnt), 32'h1);
    rdc(wdg_pkg::OFS_COUNT, 32'h0000_0000);
    rdc(wdg_pkg::OFS_STATUS, 32'h0000_0002);
    do_reset();
    rdc(wdg_pkg::OFS_CTRL, 32'h0000_0000);
    // warning off, mask clear: expiry must still come, silently
    exp_cnt = nmi_cnt;
    wr(wdg_pkg::OFS_CTRL, 32'h0000_0002, 3'h0);
    wait_on(1'b1, 200);
    chk(32'(nmi_cnt - exp_cnt), 32'h0);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(wdg_pkg::OFS_MASK, 32'h0000_0002, 3'h0);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0000_0001);
    rdc(wdg_pkg::OFS_STATUS, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0000_0000);
    test_done();
  end
endmodule
`default_nettype wire
